// [design/gpcg_pkg.sv]
package gpcg_pkg;
	// Register byte offsets
	localparam logic [7:0] PORT_B_CLOCK_GATING_OFS = 8'h58;
	localparam logic [7:0] PORT_B_SOFT_RESET_CTRL_OFS = 8'h5C;
	localparam logic [7:0] PORT_C_CLOCK_GATING_OFS = 8'h60;
	// Field positions
	localparam int RUN_CLOCK_ON_POS = 0;
	localparam int SLEEP_CLOCK_ON_POS = 8;
	localparam int DEEP_SLEEP_CLOCK_ON_POS = 16;
	localparam int SOFTWARE_RESET_HOLD_POS = 0;
	localparam int PORT_ENABLED_FLAG_POS = 1;
	// Reset values
	localparam logic [31:0] CLOCK_GATING_RST = 32'h0000_0000;
	localparam logic [31:0] SOFT_RESET_RST = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// Power mode encodings from the power manager
	localparam logic [1:0] PMODE_RUN = 2'h0;
	localparam logic [1:0] PMODE_SLEEP = 2'h1;
	localparam logic [1:0] PMODE_DEEP = 2'h2;

	// Per-port clock enable bits
	typedef struct packed {
		logic deep_sleep_clock_on;
		logic sleep_clock_on;
		logic run_clock_on;
	} gpcg_clk_en_t;

	// Bus slave states
	typedef enum logic {
		GPCG_IDLE,
		GPCG_ACK
	} gpcg_bus_state_t;
endpackage

// [design/gpcg_gate_sel.sv]
// Picks the enable bit for the present power mode and registers the gate.
module gpcg_gate_sel
	import gpcg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Controls
	input wire gpcg_clk_en_t en_i,
	input wire logic [1:0] pmode_i,
	// Gate
	output logic gate_o
);
	logic gate_ff;
	logic nxt_gate;

	// Mode mux; an unknown mode keeps the clock off
	always_comb begin
		nxt_gate = 1'b0;
		if (pmode_i == PMODE_RUN) begin
			nxt_gate = en_i.run_clock_on;
		end else if (pmode_i == PMODE_SLEEP) begin
			nxt_gate = en_i.sleep_clock_on;
		end else if (pmode_i == PMODE_DEEP) begin
			nxt_gate = en_i.deep_sleep_clock_on;
		end
	end

	// Gate register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_ff <= 1'b0;
		end else begin
			gate_ff <= nxt_gate;
		end
	end

	assign gate_o = gate_ff;
endmodule

// [design/gpcg_top.sv]
// Behaviour
// - Port B clock runs in deep sleep only while its deep-sleep enable bit 16 is set.
// - Port B clock runs in sleep only while its sleep enable bit 8 is set.
// - Port B clock runs in run mode only while its run enable bit 0 is set.
// - Port B soft-reset bit 0 holds port B in reset when 1, releases it when 0, reads back.
// - Bit 1 of the port B soft-reset register is a read-only enabled status flag.
// - Port C clock runs in deep sleep only while its deep-sleep enable bit 16 is set.
// - Port C clock runs in sleep only while its sleep enable bit 8 is set.
// - Port C clock runs in run mode only while its run enable bit 0 is set.
// - After chip reset all control bits are 0, clocks gated and soft reset released.
// - Reserved and unused bits read 0 and ignore writes.
//
// Added by the designer: the Wishbone register port.
module gpcg_top
	import gpcg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Power manager
	input wire logic [1:0] pmode_i,
	// Port controls
	output logic port_b_clk_en_o,
	output logic port_b_rst_o,
	output logic port_c_clk_en_o
);
	gpcg_bus_state_t state_ff;
	gpcg_bus_state_t nxt_state;
	gpcg_clk_en_t b_en_ff;
	gpcg_clk_en_t nxt_b_en;
	gpcg_clk_en_t c_en_ff;
	gpcg_clk_en_t nxt_c_en;
	logic b_rst_ff;
	logic nxt_b_rst;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic ack_ff;
	logic nxt_ack;
	logic [1:0] pmode_ff;
	logic [1:0] nxt_pmode;
	logic b_gate;
	logic c_gate;
	logic b_enabled;
	logic req;
	logic wr_lo;
	logic wr_hi;

	// Request qualifiers for lanes 0 and 2; lanes 0, 1 and 2 carry the only writable bits
	assign req = wb_cyc_i && wb_stb_i && (state_ff == GPCG_IDLE);
	assign wr_lo = req && wb_we_i && wb_sel_i[0];
	assign wr_hi = req && wb_we_i && wb_sel_i[2];

	// Port B counts as enabled while out of soft reset with some mode clock on
	// status flag source
	assign b_enabled = !b_rst_ff && (b_en_ff != '0);

	// Bus state: answer one cycle after the request, then drop ack
	always_comb begin
		nxt_state = state_ff;
		nxt_ack = 1'b0;
		unique case (state_ff)
			GPCG_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					nxt_state = GPCG_ACK;
					nxt_ack = 1'b1;
				end
			end
			GPCG_ACK: begin
				nxt_state = GPCG_IDLE;
			end
		endcase
	end

	// Register writes; only the named bits are stored
	always_comb begin
		nxt_b_en = b_en_ff;
		nxt_c_en = c_en_ff;
		nxt_b_rst = b_rst_ff;
		if (wb_adr_i == PORT_B_CLOCK_GATING_OFS) begin
			if (wr_lo) begin
				nxt_b_en.run_clock_on = wb_dat_i[RUN_CLOCK_ON_POS];
			end
			if (req && wb_we_i && wb_sel_i[1]) begin
				nxt_b_en.sleep_clock_on = wb_dat_i[SLEEP_CLOCK_ON_POS];
			end
			if (wr_hi) begin
				nxt_b_en.deep_sleep_clock_on = wb_dat_i[DEEP_SLEEP_CLOCK_ON_POS];
			end
		end
		if (wb_adr_i == PORT_C_CLOCK_GATING_OFS) begin
			if (wr_lo) begin
				nxt_c_en.run_clock_on = wb_dat_i[RUN_CLOCK_ON_POS];
			end
			if (req && wb_we_i && wb_sel_i[1]) begin
				nxt_c_en.sleep_clock_on = wb_dat_i[SLEEP_CLOCK_ON_POS];
			end
			if (wr_hi) begin
				nxt_c_en.deep_sleep_clock_on = wb_dat_i[DEEP_SLEEP_CLOCK_ON_POS];
			end
		end
		// soft reset write; status bit ignores writes
		if (wb_adr_i == PORT_B_SOFT_RESET_CTRL_OFS && wr_lo) begin
			nxt_b_rst = wb_dat_i[SOFTWARE_RESET_HOLD_POS];
		end
	end

	// Read data, registered with ack
	always_comb begin
		nxt_dat = UNMAPPED_READ;
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				PORT_B_CLOCK_GATING_OFS: begin
					nxt_dat[RUN_CLOCK_ON_POS] = b_en_ff.run_clock_on;
					nxt_dat[SLEEP_CLOCK_ON_POS] = b_en_ff.sleep_clock_on;
					nxt_dat[DEEP_SLEEP_CLOCK_ON_POS] = b_en_ff.deep_sleep_clock_on;
				end
				PORT_B_SOFT_RESET_CTRL_OFS: begin
					nxt_dat[SOFTWARE_RESET_HOLD_POS] = b_rst_ff;
					nxt_dat[PORT_ENABLED_FLAG_POS] = b_enabled;
				end
				PORT_C_CLOCK_GATING_OFS: begin
					nxt_dat[RUN_CLOCK_ON_POS] = c_en_ff.run_clock_on;
					nxt_dat[SLEEP_CLOCK_ON_POS] = c_en_ff.sleep_clock_on;
					nxt_dat[DEEP_SLEEP_CLOCK_ON_POS] = c_en_ff.deep_sleep_clock_on;
				end
				default: begin
					nxt_dat = UNMAPPED_READ;
				end
			endcase
		end
	end

	// Power mode pin passes two flops before the mux
	always_comb begin
		nxt_pmode = pmode_i;
	end

	logic [1:0] pmode_meta_ff;

	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= GPCG_IDLE;
			b_en_ff <= gpcg_clk_en_t'(CLOCK_GATING_RST[2:0]);
			c_en_ff <= gpcg_clk_en_t'(CLOCK_GATING_RST[2:0]);
			b_rst_ff <= SOFT_RESET_RST[SOFTWARE_RESET_HOLD_POS];
			dat_ff <= UNMAPPED_READ;
			ack_ff <= 1'b0;
			pmode_meta_ff <= PMODE_RUN;
			pmode_ff <= PMODE_RUN;
		end else begin
			state_ff <= nxt_state;
			b_en_ff <= nxt_b_en;
			c_en_ff <= nxt_c_en;
			b_rst_ff <= nxt_b_rst;
			dat_ff <= nxt_dat;
			ack_ff <= nxt_ack;
			pmode_meta_ff <= nxt_pmode;
			pmode_ff <= pmode_meta_ff;
		end
	end

	gpcg_gate_sel u_gate_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(b_en_ff),
		.pmode_i(pmode_ff),
		.gate_o(b_gate)
	);

	gpcg_gate_sel u_gate_c (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(c_en_ff),
		.pmode_i(pmode_ff),
		.gate_o(c_gate)
	);

	// Outputs straight from flops
	assign wb_dat_o = dat_ff;
	assign wb_ack_o = ack_ff;
	assign port_b_rst_o = b_rst_ff;
	assign port_b_clk_en_o = b_gate;
	assign port_c_clk_en_o = c_gate;
endmodule

// [tb/gpcg_assertions.sv]
module gpcg_chk (
	// Clock and reset
	input logic clk_i,
	input logic rst_i,
	// Bus
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	// Mode and gates
	input logic [1:0] pmode_i,
	input logic port_b_clk_en_o,
	input logic port_b_rst_o,
	input logic port_c_clk_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Read answer, and gate against its enable bit once a mode has settled
	wire rd = wb_ack_o & ~wb_we_i;
	property p_g(m, b, c);
		(pmode_i == m) [*4] ##0 rd && wb_adr_i == (c ? 8'h60 : 8'h58)
			|-> wb_dat_o[b] == (c ? port_c_clk_en_o : port_b_clk_en_o);
	endproperty
	a_rsvd_zero: assert property (wb_ack_o |-> !(wb_dat_o & 32'hFFFE_FEFC))
		else $error("reserved bit set");
	a_rst_back: assert property (rd && wb_adr_i == 8'h5C |-> wb_dat_o[0] == port_b_rst_o)
		else $error("reset bit");
	a_gate_bd: assert property (p_g(2'h2, 16, 0)) else $error("b deep gate");
	a_gate_bs: assert property (p_g(2'h1, 8, 0)) else $error("b sleep gate");
	a_gate_br: assert property (p_g(2'h0, 0, 0)) else $error("b run gate");
	a_gate_cd: assert property (p_g(2'h2, 16, 1)) else $error("c deep gate");
	a_gate_cs: assert property (p_g(2'h1, 8, 1)) else $error("c sleep gate");
	a_gate_cr: assert property (p_g(2'h0, 0, 1)) else $error("c run gate");
	a_mode_off: assert property ((pmode_i == 2'h3) [*4]
		|-> !port_b_clk_en_o && !port_c_clk_en_o) else $error("clock on in off mode");
	c_rd: cover property (rd && wb_adr_i == 8'h5C);
	c_wr: cover property (wb_ack_o && wb_we_i);
	c_off: cover property (pmode_i == 2'h3);
endmodule

// [tb/test_gpcg_top.sv]
module test_gpcg_top;
	timeunit 1ns;
	timeprecision 1ns;
	// Drive, outputs and model
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0;
	logic [1:0] pm = 2'h0;
	logic [3:0] sel = 4'h0;
	logic [7:0] adr = 8'h0;
	logic [31:0] dat = 32'h0, q, got, b, r, c;
	logic ack, pbc, pbr, pcc;
	int err_total = 0, comparisons = 0;
	always #50 clk_i = ~clk_i;
	gpcg_top gpcg_top_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
		.pmode_i(pm), .port_b_clk_en_o(pbc), .port_b_rst_o(pbr), .port_c_clk_en_o(pcc));
	task automatic cmp(string s, logic [31:0] e, v);
		comparisons++;
		if (v !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, e, v);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		// The wait ends on ack, or at the watchdog if it hangs; the slave answers at the second edge
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'h1);
		cmp("ack wait", 32'h2, n);
		got = q;
		cyc <= 1'h0;
	endtask
	// Write, then apply lane and writable masks to the model
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		m &= a == 8'h5C ? 32'h1 : 32'h0001_0101;
		bus(1'h1, a, d, s);
		if (a == 8'h58) b = b & ~m | d & m;
		if (a == 8'h5C) r = r & ~m | d & m;
		if (a == 8'h60) c = c & ~m | d & m;
	endtask
	// Read and compare with the model
	task automatic rd(logic [7:0] a);
		logic [31:0] e;
		e = 32'h0;
		if (a == 8'h58) e = b;
		if (a == 8'h60) e = c;
		if (a == 8'h5C) e = r | {30'h0, !r[0] && b != 32'h0, 1'h0};
		bus(1'h0, a, 32'h0, 4'hF);
		cmp("read", e, got);
	endtask
	// Settle a mode, then compare gates with the selected bits
	task automatic gate(logic [1:0] m);
		pm <= m;
		repeat (4) @(posedge clk_i);
		cmp("b gate", b[8 * m], pbc);
		cmp("c gate", c[8 * m], pcc);
		cmp("b reset", r, pbr);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Main sequence with a second reset halfway
	initial begin
		void'($urandom(32'hF2DBC44C));
		{b, r, c} = '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		for (int i = 0; i < 80; i++) begin
			if (i == 40) begin
				rst_i <= 1'h1;
				@(posedge clk_i);
				rst_i <= 1'h0;
				{b, r, c} = '0;
			end
			for (int k = 0; k < 4; k++) rd(8'h58 + 8'(4 * k));
			rd(8'($urandom));
			wr(8'h58 + 8'(4 * ($urandom % 4)), $urandom, 4'($urandom));
			gate(2'(i));
		end
		tally_and_finish;
	end
	// Hang guard far beyond the run length
	initial begin
		#2ms;
		err_total++;
		tally_and_finish;
	end
endmodule
bind gpcg_top gpcg_chk gpcg_chk_i (.clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .pmode_i, .port_b_clk_en_o, .port_b_rst_o, .port_c_clk_en_o);
